// ---- pkg/supply_status_defs.vh ----
// Constants for the supply turn-on timeout and status bank
// How it works
// R1 - Limit 0001h..7FFFh: assert enable, rail must pass UV fault level in time
// R2 - Limit 0000h: assert enable, monitor, no wait; crossing never gates next slot
// R3 - Host should use general output, slot 0, zero delay for monitor-only channels
// R4 - Limit 8000h..FFFFh: overvoltage and undervoltage monitoring defeated
// R5 - Each page pairs one rail sense input with one enable output
// R6 - General-output configuration overrides sequencing control of the enable output
// R7 - Limit is a two-byte millisecond count from enable to UV crossing
// R8 - Negative limit: no sequencing, enable held low, voltage faults off
// R9 - Timeout sets summary voltage bit, timeout bit, fault action, alert
// R10 - Clear while condition persists sets the status bit again at once
// R11 - After alert clear, only new events reassert the alert output
// R12 - Summary word 16 bits; bit 15 voltage; bits 14,13,10,9,7,4,3,0 zero
// R13 - Summary bit 11 is OR of all power-good-lost flags
// R14 - Summary bit 6 is OR of all sequenced-off flags
// R15 - Bits 12 vendor, 8 margin, 5 OV fault, 2 temperature, 1 comms
// R16 - Any-channel-off and power-good-lost bits never raise the alert
// R17 - Voltage status latched; conditions reset again, timeout only on new event
// R18 - Voltage byte: 7 OVF, 6 OVW, 5 UVW, 4 UVF, 2 timeout, others zero
// R19 - Temperature byte: 7 fault, 6 warning, latched, persist sets again
// R20 - Comms byte: 7 bad command, 6 bad data, new occurrence only; code latches the input level, so a persisting input sets again
// R21 - Comms bit 0 tracks log-full in real time, unlatched
// R22 - With wrap enabled, log-full clears once an overwrite happens
// R23 - Timeout count starts on each enable rise, stops on crossing or deassertion
`ifndef SUPPLY_STATUS_DEFS_VH
`define SUPPLY_STATUS_DEFS_VH
`define CMD_TURN_ON_LIMIT    8'h62
`define CMD_SUMMARY_WORD     8'h79
`define CMD_VOUT_STATUS      8'h7a
`define CMD_TEMP_STATUS      8'h7d
`define CMD_COMM_STATUS      8'h7e
`define LIMIT_RESET          16'h0000
`define MS_TIME              1
`define CLK_MHZ              100
`define CYCLES_PER_MS        (`MS_TIME * `CLK_MHZ * 1000)
`define VO_OVF_BIT           7
`define VO_OVW_BIT           6
`define VO_UVW_BIT           5
`define VO_UVF_BIT           4
`define VO_TON_BIT           2
`define SW_VOUT_BIT          15
`define SW_MFR_BIT           12
`define SW_PGL_BIT           11
`define SW_MARGIN_BIT        8
`define SW_OFF_BIT           6
`define SW_OV_BIT            5
`define SW_TEMP_BIT          2
`define SW_CML_BIT           1
`endif

// ---- logic/turn_on_channel.v ----
// One channel: turn-on limit mode decode, timeout count and voltage status
`timescale 1ns/1ns
`include "supply_status_defs.vh"
module turn_on_channel
(
	input  wire        clk_i,
	input  wire        nrst_i,
	input  wire        ms_tick_i,
	input  wire [15:0] limit_i,
	input  wire        seq_on_i,
	input  wire        gpo_mode_i,
	input  wire        gpo_level_i,
	input  wire        above_uvf_i,
	input  wire        ovf_i,
	input  wire        ovw_i,
	input  wire        uvw_i,
	input  wire        uvf_i,
	input  wire        clear_i,
	output reg         supply_enable_out_o,
	output wire [7:0]  vout_status_o,
	output wire        timeout_event_o,
	output wire        new_event_o,
	output wire        off_flag_o,
	output wire        slot_done_o
);
	// ****************************************
	// Mode decode
	// ****************************************
	wire        off_mode   = limit_i[15];                      // R4 R8
	wire        blind_mode = (limit_i == 16'h0000);            // R2
	wire        enable_int = seq_on_i & ~off_mode;             // R8
	wire        mon_en     = ~off_mode;                        // R4
	reg  [15:0] ms_cnt_reg;
	reg         waiting_reg;
	reg         crossed_reg;
	reg  [4:0]  vo_reg;
	reg  [3:0]  cond_d_reg;

	// ****************************************
	// Timeout counter
	// ****************************************
	// Timeout is one pulse per wait so a cleared bit only returns on a new event
	assign timeout_event_o = waiting_reg & ms_tick_i & (ms_cnt_reg + 16'h0001 >= limit_i)
		& ~above_uvf_i;                                        // R1 R7 R9
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ms_cnt_reg  <= 16'h0000;
			waiting_reg <= 1'b0;
			crossed_reg <= 1'b0;
		end
		else if (!enable_int)
		begin
			waiting_reg <= 1'b0;                               // R23
			crossed_reg <= 1'b0;
			ms_cnt_reg  <= 16'h0000;
		end
		else if (!supply_enable_out_o)
		begin
			waiting_reg <= ~blind_mode;                        // R23 R2
			ms_cnt_reg  <= 16'h0000;
		end
		else if (waiting_reg)
		begin
			if (above_uvf_i)
			begin
				waiting_reg <= 1'b0;                           // R23
				crossed_reg <= 1'b1;
			end
			else if (timeout_event_o)
				waiting_reg <= 1'b0;
			else if (ms_tick_i)
				ms_cnt_reg <= ms_cnt_reg + 16'h0001;
		end
	end

	// Sequencing drive unless general-output use overrides
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			supply_enable_out_o <= 1'b0;
		else if (gpo_mode_i)
			supply_enable_out_o <= gpo_level_i;                // R6
		else
			supply_enable_out_o <= enable_int;                 // R1 R5 R8
	end

	// ****************************************
	// Voltage status byte
	// ****************************************
	wire [3:0] cond = {ovf_i, ovw_i, uvw_i, uvf_i} & {4{mon_en}}; // R4 R5
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			vo_reg     <= 5'h00;
			cond_d_reg <= 4'h0;
		end
		else
		begin
			cond_d_reg <= cond;
			// Set wins over clear; persisting conditions reset at once
			vo_reg <= ((clear_i ? 5'h00 : vo_reg) | {cond, timeout_event_o}); // R10 R17
		end
	end
	assign new_event_o = |(cond & ~cond_d_reg) | timeout_event_o;  // R11
	assign vout_status_o = {vo_reg[4], vo_reg[3], vo_reg[2], vo_reg[1], 1'b0,
		vo_reg[0], 2'b00};                                     // R18
	assign off_flag_o  = ~off_mode & ~supply_enable_out_o & ~gpo_mode_i;
	assign slot_done_o = blind_mode | crossed_reg;             // R2
endmodule // turn_on_channel

// ---- logic/supply_status_bank.v ----
// Status bank: per-channel turn-on logic, summary word and alert output
`timescale 1ns/1ns
`include "supply_status_defs.vh"
module supply_status_bank
#(
	parameter CHANNELS  = 16,
	parameter MS_CYCLES = `CYCLES_PER_MS
)
(
	input  wire                  clk_i,
	input  wire                  nrst_i,
	input  wire [7:0]            page_i,
	input  wire [7:0]            cmd_i,
	input  wire                  wr_i,
	input  wire [15:0]           wdata_i,
	input  wire                  clear_faults_i,
	input  wire                  alert_clear_i,
	input  wire                  alert_enable_i,
	input  wire [CHANNELS-1:0]   seq_on_i,
	input  wire [CHANNELS-1:0]   enable_pin_gpo_config_i,
	input  wire [CHANNELS-1:0]   gpo_level_i,
	input  wire [CHANNELS-1:0]   above_uvf_i,
	input  wire [CHANNELS-1:0]   ovf_i,
	input  wire [CHANNELS-1:0]   ovw_i,
	input  wire [CHANNELS-1:0]   uvw_i,
	input  wire [CHANNELS-1:0]   uvf_i,
	input  wire [CHANNELS-1:0]   pg_lost_i,
	input  wire [CHANNELS-1:0]   margin_fault_i,
	input  wire                  vendor_status_i,
	input  wire                  ot_fault_i,
	input  wire                  ot_warn_i,
	input  wire                  bad_cmd_i,
	input  wire                  bad_data_i,
	input  wire                  log_full_i,
	input  wire                  log_wrap_enable_i,
	input  wire                  log_overwrite_i,
	output wire [CHANNELS-1:0]   supply_enable_out_o,
	output wire [CHANNELS-1:0]   slot_done_o,
	output wire [CHANNELS-1:0]   fault_action_o,
	output reg  [15:0]           rdata_o,
	output reg                   alert_o
);
	// ****************************************
	// Millisecond enable
	// ****************************************
	reg  [16:0] div_reg;
	wire        ms_tick = (div_reg == MS_CYCLES - 1);
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			div_reg <= 17'h00000;
		else if (ms_tick)
			div_reg <= 17'h00000;
		else
			div_reg <= div_reg + 17'h00001;
	end

	// ****************************************
	// Channels
	// ****************************************
	reg  [15:0]          limit_reg [0:CHANNELS-1];
	wire [7:0]           vo_st [0:CHANNELS-1];
	wire [CHANNELS-1:0]  ton_ev;
	wire [CHANNELS-1:0]  new_ev;
	wire [CHANNELS-1:0]  off_flag;
	wire                 pg_sel = (page_i < CHANNELS);
	wire [3:0]           pidx = page_i[3:0];
	integer i;
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (i = 0; i < CHANNELS; i = i + 1)
				limit_reg[i] <= `LIMIT_RESET;
		end
		else if (wr_i && cmd_i == `CMD_TURN_ON_LIMIT)
		begin
			for (i = 0; i < CHANNELS; i = i + 1)
				if (page_i == 8'hff || page_i == i[7:0])
					limit_reg[i] <= wdata_i;                   // R7
		end
	end
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : ch
			turn_on_channel u_ch
			(
				.clk_i               (clk_i),
				.nrst_i              (nrst_i),
				.ms_tick_i           (ms_tick),
				.limit_i             (limit_reg[g]),
				.seq_on_i            (seq_on_i[g]),
				.gpo_mode_i          (enable_pin_gpo_config_i[g]),
				.gpo_level_i         (gpo_level_i[g]),
				.above_uvf_i         (above_uvf_i[g]),
				.ovf_i               (ovf_i[g]),
				.ovw_i               (ovw_i[g]),
				.uvw_i               (uvw_i[g]),
				.uvf_i               (uvf_i[g]),
				.clear_i             (clear_faults_i),
				.supply_enable_out_o (supply_enable_out_o[g]),
				.vout_status_o       (vo_st[g]),
				.timeout_event_o     (ton_ev[g]),
				.new_event_o         (new_ev[g]),
				.off_flag_o          (off_flag[g]),
				.slot_done_o         (slot_done_o[g])
			);
			assign fault_action_o[g] = ton_ev[g] | (ovf_i[g] | uvf_i[g]) & ~limit_reg[g][15]; // R9
		end
	endgenerate

	// ****************************************
	// Device-wide latched status and unlatched log-full bit
	// ****************************************
	reg  [1:0] temp_reg;
	reg  [1:0] cml_reg;
	reg  [1:0] ot_d_reg;
	reg        full_reg;
	reg        full_d_reg;
	reg        bad_d_reg;
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			temp_reg  <= 2'b00;
			cml_reg   <= 2'b00;
			ot_d_reg  <= 2'b00;
			bad_d_reg <= 1'b0;
			full_reg  <= 1'b0;
			full_d_reg <= 1'b0;
		end
		else
		begin
			ot_d_reg  <= {ot_fault_i, ot_warn_i};
			bad_d_reg <= bad_cmd_i | bad_data_i;
			temp_reg  <= (clear_faults_i ? 2'b00 : temp_reg) | {ot_fault_i, ot_warn_i}; // R19 R10
			cml_reg   <= (clear_faults_i ? 2'b00 : cml_reg) | {bad_cmd_i, bad_data_i};   // R20
			full_d_reg <= log_full_i;
			// Overwrite erases two records, so the bit stays clear until the log fills again
			if (!log_wrap_enable_i)
				full_reg <= log_full_i;                        // R21
			else if (log_overwrite_i)
				full_reg <= 1'b0;                              // R22
			else if (log_full_i && !full_d_reg)
				full_reg <= 1'b1;                              // R22
			else if (!log_full_i)
				full_reg <= 1'b0;                              // R21
		end
	end

	// ****************************************
	// Summary word
	// ****************************************
	reg [7:0] vo_or;
	reg       ovf_any;
	always @*
	begin
		vo_or = 8'h00;
		for (i = 0; i < CHANNELS; i = i + 1)
			vo_or = vo_or | vo_st[i];
		ovf_any = vo_or[`VO_OVF_BIT];
	end
	wire [15:0] summary;
	assign summary[`SW_VOUT_BIT]   = |vo_or;                   // R12
	assign summary[14:13]          = 2'b00;                    // R12
	assign summary[`SW_MFR_BIT]    = vendor_status_i;          // R15
	assign summary[`SW_PGL_BIT]    = |pg_lost_i;               // R13
	assign summary[10:9]           = 2'b00;
	assign summary[`SW_MARGIN_BIT] = |margin_fault_i;          // R15
	assign summary[7]              = 1'b0;
	assign summary[`SW_OFF_BIT]    = |off_flag;                // R14
	assign summary[`SW_OV_BIT]     = ovf_any;                  // R15
	assign summary[4:3]            = 2'b00;
	assign summary[`SW_TEMP_BIT]   = |temp_reg;                // R15
	assign summary[`SW_CML_BIT]    = |cml_reg;                 // R15
	assign summary[0]              = 1'b0;

	// ****************************************
	// Alert
	// ****************************************
	// Only edges raise the alert; off and power-good-lost are left out on purpose
	wire new_event = |new_ev | |({ot_fault_i, ot_warn_i} & ~ot_d_reg)
		| ((bad_cmd_i | bad_data_i) & ~bad_d_reg);             // R11 R16
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			alert_o <= 1'b0;
		else if (new_event && alert_enable_i)
			alert_o <= 1'b1;                                   // R9 R11
		else if (alert_clear_i || clear_faults_i)
			alert_o <= 1'b0;
	end

	// ****************************************
	// Read mux
	// ****************************************
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_o <= 16'h0000;
		else if (cmd_i == `CMD_TURN_ON_LIMIT)
			rdata_o <= pg_sel ? limit_reg[pidx] : 16'h0000;
		else if (cmd_i == `CMD_SUMMARY_WORD)
			rdata_o <= summary;
		else if (cmd_i == `CMD_VOUT_STATUS)
			rdata_o <= {8'h00, pg_sel ? vo_st[pidx] : vo_or};
		else if (cmd_i == `CMD_TEMP_STATUS)
			rdata_o <= {8'h00, temp_reg, 6'h00};
		else if (cmd_i == `CMD_COMM_STATUS)
			rdata_o <= {8'h00, cml_reg, 5'h00, full_reg};
		else
			rdata_o <= 16'h0000;
	end
endmodule // supply_status_bank

// ---- tb/supply_status_monitor.sv ----
// Port checker for the supply status bank
`timescale 1ns/1ns
module supply_status_monitor
#(
	parameter CHANNELS = 16
)
(
	input wire                clk_i,
	input wire                nrst_i,
	input wire [7:0]          page_i,
	input wire [7:0]          cmd_i,
	input wire                wr_i,
	input wire [15:0]         wdata_i,
	input wire                alert_enable_i,
	input wire [CHANNELS-1:0] enable_pin_gpo_config_i,
	input wire [CHANNELS-1:0] gpo_level_i,
	input wire [CHANNELS-1:0] above_uvf_i,
	input wire [CHANNELS-1:0] pg_lost_i,
	input wire                vendor_status_i,
	input wire                log_full_i,
	input wire                log_wrap_enable_i,
	input wire [CHANNELS-1:0] supply_enable_out_o,
	input wire [CHANNELS-1:0] slot_done_o,
	input wire [15:0]         rdata_o,
	input wire                alert_o
);
	// ****
	// Limit mirror, so modes are known per channel
	// ****
	reg  [15:0]         lim_reg [0:CHANNELS-1];
	wire [CHANNELS-1:0] neg_w;
	wire [CHANNELS-1:0] zero_w;
	wire [CHANNELS-1:0] std_w;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : mir
			always @(posedge clk_i or negedge nrst_i)
				if (!nrst_i)
					lim_reg[g] <= 16'h0000;
				else if (wr_i && cmd_i == 8'h62 && (page_i == 8'hff || page_i == g))
					lim_reg[g] <= wdata_i;
			assign neg_w[g] = lim_reg[g][15];
			assign zero_w[g] = lim_reg[g] == 16'h0000;
		end
	endgenerate
	assign std_w = ~neg_w & ~zero_w;
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Enable rising on a timed channel before any crossing
	sequence std_rise_s;
		(supply_enable_out_o & ~$past(supply_enable_out_o) & std_w & ~above_uvf_i) != 0;
	endsequence
	word_zero_a: assert property (cmd_i == 8'h79 |=> (rdata_o & 16'h6699) == 16'h0000)
		else $error("summary reserved bit set");
	vout_zero_a: assert property (cmd_i == 8'h7a |=> (rdata_o & 16'hff0b) == 16'h0000)
		else $error("voltage reserved bit set");
	temp_zero_a: assert property (cmd_i == 8'h7d |=> (rdata_o & 16'hff3f) == 16'h0000)
		else $error("temperature reserved bit set");
	comm_zero_a: assert property (cmd_i == 8'h7e |=> (rdata_o & 16'hff3e) == 16'h0000)
		else $error("comms reserved bit set");
	log_track_a: assert property (cmd_i == 8'h7e && !log_wrap_enable_i
		&& !$past(log_wrap_enable_i) |=> rdata_o[0] == $past(log_full_i, 2))
		else $error("log full bit lags");
	pg_or_a: assert property (cmd_i == 8'h79 |=> rdata_o[11] == |($past(pg_lost_i)))
		else $error("power good lost summary wrong");
	vendor_bit_a: assert property (cmd_i == 8'h79 && vendor_status_i |=> rdata_o[12])
		else $error("vendor summary bit missing");
	alert_gate_a: assert property ($rose(alert_o) |-> $past(alert_enable_i))
		else $error("alert raised while disabled");
	gpo_over_a: assert property (enable_pin_gpo_config_i != 0 |=>
		((supply_enable_out_o ^ $past(gpo_level_i)) & $past(enable_pin_gpo_config_i)) == 0)
		else $error("general output not followed");
	off_hold_a: assert property ((neg_w & $past(neg_w) & supply_enable_out_o
		& ~$past(enable_pin_gpo_config_i)) == 0) else $error("off channel enabled");
	blind_done_a: assert property ((zero_w & supply_enable_out_o & ~slot_done_o) == 0)
		else $error("blind channel gates slot");
	std_wait_a: assert property (std_rise_s |-> (slot_done_o & std_w & ~above_uvf_i) == 0)
		else $error("timed channel done early");
endmodule // supply_status_monitor

// ---- tb/pmbus_host_model.sv ----
// Host side model: drives page, command and write strobe
`timescale 1ns/1ns
module pmbus_host_model
(
	input  wire        clk_i,
	input  wire [15:0] rdata_i,
	output reg  [7:0]  page_o,
	output reg  [7:0]  cmd_o,
	output reg         wr_o,
	output reg  [15:0] wdata_o
);
	initial
	begin
		{page_o, cmd_o, wr_o, wdata_o} = 33'h0;
	end
	// Strobe held one full cycle so exactly one edge takes it
	task put(input [7:0] pg, input [15:0] d);
	begin
		@(negedge clk_i);
		{page_o, cmd_o, wdata_o, wr_o} = {pg, 8'h62, d, 1'b1};
		@(negedge clk_i);
		wr_o = 1'b0;
	end
	endtask
	// Two edges so status changes made beside the request have landed
	task get(input [7:0] pg, input [7:0] c, output [15:0] d);
	begin
		@(negedge clk_i);
		{page_o, cmd_o} = {pg, c};
		repeat (2) @(negedge clk_i);
		d = rdata_i;
	end
	endtask
endmodule // pmbus_host_model

// ---- tb/supply_turn_on_timeout_and_status_bench.sv ----
// Self-checking bench for the supply status bank
`timescale 1ns/1ns
module supply_turn_on_timeout_and_status_bench;
	localparam CHANNELS = 16;
	localparam MS_CYCLES = 50;
	reg        clk_i, nrst_i, clear_faults_i, alert_clear_i, alert_enable_i, vendor_status_i;
	reg        ot_fault_i, ot_warn_i, bad_cmd_i, bad_data_i;
	reg        log_full_i, log_wrap_enable_i, log_overwrite_i;
	reg [15:0] seq_on_i, enable_pin_gpo_config_i, gpo_level_i, above_uvf_i;
	reg [15:0] ovf_i, ovw_i, uvw_i, uvf_i, pg_lost_i, margin_fault_i, rd_v;
	wire [7:0] page_i, cmd_i;
	wire       wr_i, alert_o;
	wire [15:0] wdata_i, rdata_o, supply_enable_out_o, slot_done_o, fault_action_o;
	reg [31:0] r;
	integer    n_errors, cmp_count, k;
	pmbus_host_model pmbus_host_model_i
	(
		.clk_i, .rdata_i(rdata_o), .page_o(page_i), .cmd_o(cmd_i), .wr_o(wr_i), .wdata_o(wdata_i)
	);
	supply_status_bank #(.CHANNELS(CHANNELS), .MS_CYCLES(MS_CYCLES)) supply_status_bank_i
	(
		.clk_i, .nrst_i, .page_i, .cmd_i, .wr_i, .wdata_i, .clear_faults_i, .alert_clear_i,
		.alert_enable_i, .seq_on_i, .enable_pin_gpo_config_i, .gpo_level_i, .above_uvf_i,
		.ovf_i, .ovw_i, .uvw_i, .uvf_i, .pg_lost_i, .margin_fault_i, .vendor_status_i,
		.ot_fault_i, .ot_warn_i, .bad_cmd_i, .bad_data_i, .log_full_i, .log_wrap_enable_i,
		.log_overwrite_i, .supply_enable_out_o, .slot_done_o, .fault_action_o, .rdata_o,
		.alert_o
	);
	// ****
	// Shared tasks
	// ****
	function [15:0] word_exp(input [15:0] pg, input v, input [15:0] mf);
		word_exp = {3'b000, v, |pg, 2'b00, |mf, 1'b0, 1'b1, 6'h00};
	endfunction
	task stop_test;
	begin
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task check(input [8*8-1:0] what, input [15:0] seen, input [15:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("unexpected %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task rd(input [7:0] pg, input [7:0] c);
		pmbus_host_model_i.get(pg, c, rd_v);
	endtask
	// One task for all strobes keeps each pulse exactly one cycle
	task pulse(input [2:0] p);
	begin
		@(negedge clk_i);
		{log_overwrite_i, bad_data_i, bad_cmd_i, alert_clear_i, clear_faults_i} = 5'h01 << p;
		@(negedge clk_i);
		{log_overwrite_i, bad_data_i, bad_cmd_i, alert_clear_i, clear_faults_i} = 5'h00;
		repeat (2) @(negedge clk_i);
	end
	endtask
	task wait_en(input [15:0] m, input [15:0] e);
	begin
		for (k = 0; k < 20 && (supply_enable_out_o & m) !== e; k = k + 1)
			@(negedge clk_i);
		check("enable", supply_enable_out_o & m, e);
		if ((supply_enable_out_o & m) !== e)
			stop_test;
	end
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ****
	// Main sequence
	// ****
	initial
	begin
		{nrst_i, clear_faults_i, alert_clear_i, alert_enable_i, vendor_status_i, ot_fault_i} = 0;
		{ot_warn_i, bad_cmd_i, bad_data_i, log_full_i, log_wrap_enable_i, log_overwrite_i} = 0;
		{seq_on_i, enable_pin_gpo_config_i, gpo_level_i, above_uvf_i, ovf_i, ovw_i} = 0;
		{uvw_i, uvf_i, pg_lost_i, margin_fault_i} = 0;
		n_errors = 0;
		cmp_count = 0;
		r = $urandom(54792);
		repeat (10) @(negedge clk_i);
		nrst_i = 1'b1;
		for (k = 0; k < 8; k = k + 1)
		begin
			r = $urandom;
			pg_lost_i = r[0] ? 16'h0001 << r[7:4] : 16'h0000;
			margin_fault_i = r[2] ? 16'h0001 << r[11:8] : 16'h0000;
			vendor_status_i = r[1];
			rd(8'h00, 8'h79);
			check("word", rd_v & 16'h1940,
				word_exp(pg_lost_i, vendor_status_i, margin_fault_i));
		end
		{pg_lost_i, vendor_status_i, margin_fault_i} = 0;
		$display("summary test done");
		ot_fault_i = 1'b1;
		rd(8'h00, 8'h7d);
		ot_fault_i = 1'b0;
		rd(8'h00, 8'h7d);
		check("temp", rd_v, 16'h0080);
		ot_warn_i = 1'b1;
		pulse(0);
		rd(8'h00, 8'h7d);
		check("temp", rd_v, 16'h0040);
		rd(8'h00, 8'h79);
		check("word", rd_v & 16'h0004, 16'h0004);
		ot_warn_i = 1'b0;
		pulse(2);
		log_full_i = 1'b1;
		rd(8'h00, 8'h7e);
		check("comm", rd_v, 16'h0081);
		pulse(0);
		rd(8'h00, 8'h7e);
		check("comm", rd_v, 16'h0001);
		log_wrap_enable_i = 1'b1;
		pulse(4);
		rd(8'h00, 8'h7e);
		check("comm", rd_v, 16'h0000);
		{log_full_i, log_wrap_enable_i} = 0;
		$display("status byte test done");
		alert_enable_i = 1'b1;
		ovf_i = 16'h0001;
		rd(8'h00, 8'h7a);
		check("vout", rd_v, 16'h0080);
		check("alert", alert_o, 1'b1);
		check("action", fault_action_o[0], 1'b1);
		rd(8'h00, 8'h79);
		check("word", rd_v & 16'h8020, 16'h8020);
		pulse(1);
		pg_lost_i = 16'h0004;
		rd(8'h00, 8'h79);
		check("alert", alert_o, 1'b0);
		pulse(2);
		check("alert", alert_o, 1'b1);
		alert_enable_i = 1'b0;
		pulse(0);
		pulse(3);
		check("alert", alert_o, 1'b0);
		$display("alert test done");
		r = $urandom;
		pmbus_host_model_i.put(8'h00, 16'h8000 | r[15:0]);
		seq_on_i = 16'h0001;
		pulse(0);
		rd(8'h00, 8'h7a);
		check("vout", rd_v, 16'h0000);
		check("enable", supply_enable_out_o[0], 1'b0);
		check("action", fault_action_o[0], 1'b0);
		{ovf_i, pg_lost_i} = 0;
		pmbus_host_model_i.put(8'h00, 16'h0005);
		pmbus_host_model_i.put(8'h03, 16'h0000);
		seq_on_i = 16'h0009;
		wait_en(16'h000f, 16'h0009);
		check("slot", slot_done_o & 16'h0009, 16'h0008);
		above_uvf_i = 16'h0001;
		@(negedge clk_i);
		check("slot", slot_done_o & 16'h0009, 16'h0009);
		enable_pin_gpo_config_i = 16'h0008;
		gpo_level_i = 16'h0000;
		wait_en(16'h000f, 16'h0001);
		seq_on_i = 16'h0000;
		wait_en(16'h000f, 16'h0000);
		rd(8'h00, 8'h62);
		check("limit", rd_v, 16'h0005);
		{above_uvf_i, alert_enable_i, seq_on_i} = {16'h0000, 1'b1, 16'h0001};
		wait_en(16'h0001, 16'h0001);
		for (k = 0; k < 260 && alert_o !== 1'b1; k = k + 1)
			@(negedge clk_i);
		check("alert", alert_o, 1'b1);
		if (alert_o !== 1'b1)
			stop_test;
		check("wait", k > 200 && k < 251, 1'b1);
		rd(8'h00, 8'h7a);
		check("vout", rd_v, 16'h0004);
		rd(8'h00, 8'h79);
		check("word", rd_v & 16'h8000, 16'h8000);
		pulse(0);
		rd(8'h00, 8'h7a);
		check("vout", rd_v, 16'h0000);
		$display("turn on test done");
		stop_test;
	end
endmodule // supply_turn_on_timeout_and_status_bench
bind supply_status_bank supply_status_monitor #(.CHANNELS(CHANNELS)) supply_status_monitor_i
(
	.clk_i, .nrst_i, .page_i, .cmd_i, .wr_i, .wdata_i, .alert_enable_i,
	.enable_pin_gpo_config_i, .gpo_level_i, .above_uvf_i, .pg_lost_i, .vendor_status_i,
	.log_full_i, .log_wrap_enable_i, .supply_enable_out_o, .slot_done_o, .rdata_o, .alert_o
);
